// File: verilog/macr_pkg.sv
// Constants, register map and types for the MAC accumulator readout block
package macr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ACC_FULL_W = 48;
  localparam int unsigned ADDR_W     = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_OPERAND_A  = 8'h04;
  localparam logic [7:0] OFS_OPERAND_B  = 8'h08;
  localparam logic [7:0] OFS_ACC_HIGH   = 8'h0C;
  localparam logic [7:0] OFS_ACC_MIDDLE = 8'h10;
  localparam logic [7:0] OFS_ACC_LOW    = 8'h14;
  localparam logic [7:0] OFS_RES_UPPER  = 8'h18;
  localparam logic [7:0] OFS_RES_LOWER  = 8'h1C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Control word, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;
    logic acc_write_inhibit;
    logic clear_data_regs;
    logic square_enable;
    logic operand_count_sel;
    logic negate_subtract_sel;
    logic accumulate_enable;
    logic unsigned_select;
  } macr_ctrl_type;

  typedef enum {
    REG_CONTROL,
    REG_OPERAND_A,
    REG_OPERAND_B,
    REG_ACC_HIGH,
    REG_ACC_MIDDLE,
    REG_ACC_LOW,
    REG_RES_UPPER,
    REG_RES_LOWER,
    REG_NONE
  } macr_reg_type;

endpackage : macr_pkg

// File: verilog/macr_mac_accumulator_readout.sv
// APB multiply-accumulate unit: operands, 48-bit accumulator, result readback
`timescale 1ns/1ps

module macr_mac_accumulator_readout
  import macr_pkg::*;
#(
  parameter int unsigned ACC_WIDTH = 48            // 48, or 32 without high word
)
(
  input  wire logic              pclk,             // APB clock, 100 MHz
  input  wire logic              presetn,          // Async reset, active low
  input  wire logic [ADDR_W-1:0] paddr,            // Byte address
  input  wire logic              psel,             // Slave select
  input  wire logic              penable,          // Access phase
  input  wire logic              pwrite,           // Write when high
  input  wire logic [31:0]       pwdata,           // Write data
  output logic      [31:0]       prdata,           // Read data
  output logic                   pready,           // Always ready
  output logic                   pslverr           // Unmapped address
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [47:0] ACC_MASK = (ACC_WIDTH > 32) ? 48'hFFFF_FFFF_FFFF
                                                      : 48'h0000_FFFF_FFFF;
  localparam int unsigned TOP = ACC_WIDTH - 1;

  macr_ctrl_type ctrl;
  logic [15:0]   operand_first;
  logic [15:0]   operand_second;
  logic [15:0]   accumulator_high_word;
  logic [15:0]   accumulator_middle_word;
  logic [15:0]   accumulator_low_word;
  logic [15:0]   result_upper_readback;
  logic [15:0]   result_lower_readback;
  logic          loaded_first;
  logic          loaded_second;
  logic          pending;
  logic          op_start;
  logic          wr_access;
  logic          clear_now;
  logic          hi_write;
  macr_reg_type  wr_reg;
  macr_reg_type  rd_reg;
  logic [47:0]   acc_full;
  logic [31:0]   prod_u;
  logic signed [31:0] prod_s;
  logic [47:0]   prod48;
  logic [47:0]   sum48;
  logic [47:0]   addend;
  logic          next_overflow;

  function automatic macr_reg_type decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFS_CONTROL:    decode = REG_CONTROL;
      OFS_OPERAND_A:  decode = REG_OPERAND_A;
      OFS_OPERAND_B:  decode = REG_OPERAND_B;
      OFS_ACC_HIGH:   decode = (ACC_WIDTH > 32) ? REG_ACC_HIGH : REG_NONE;
      OFS_ACC_MIDDLE: decode = REG_ACC_MIDDLE;
      OFS_ACC_LOW:    decode = REG_ACC_LOW;
      OFS_RES_UPPER:  decode = REG_RES_UPPER;
      OFS_RES_LOWER:  decode = REG_RES_LOWER;
      default:        decode = REG_NONE;
    endcase
  endfunction : decode

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign wr_reg    = decode(paddr);
  assign rd_reg    = wr_reg;
  assign pslverr   = psel && penable && (wr_reg == REG_NONE);
  assign clear_now = wr_access && (wr_reg == REG_CONTROL) && pwdata[5];
  assign hi_write  = wr_access && (wr_reg == REG_ACC_HIGH);

  // Final operand: square or single-operand mode, or the other one already in
  always_comb
  begin
    op_start = 1'b0;
    if (wr_access && !clear_now)
    begin
      if (wr_reg == REG_OPERAND_A)
        op_start = ctrl.square_enable || ctrl.operand_count_sel || loaded_second;
      else if (wr_reg == REG_OPERAND_B)
        op_start = ctrl.square_enable || ctrl.operand_count_sel || loaded_first;
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  assign acc_full = {accumulator_high_word, accumulator_middle_word,
                     accumulator_low_word};

  always_comb
  begin
    prod_u = 32'(operand_first) * 32'(operand_second);
    prod_s = $signed(operand_first) * $signed(operand_second);
    prod48 = ctrl.unsigned_select ? {16'h0000, prod_u} : {{16{prod_s[31]}}, prod_s};
    prod48 = prod48 & ACC_MASK;
    addend = ctrl.accumulate_enable ? acc_full : 48'h0000_0000_0000;
    sum48  = ctrl.negate_subtract_sel ? (addend - prod48) : (addend + prod48);
    sum48  = sum48 & ACC_MASK;
  end

  // Purely combinational so a control or operand change shows at once
  assign result_upper_readback = sum48[31:16];
  assign result_lower_readback = sum48[15:0];

  // Signed overflow uses the top accumulator bit as sign
  always_comb
  begin
    next_overflow = 1'b0;
    if (ctrl.accumulate_enable && !ctrl.acc_write_inhibit)
    begin
      if (ctrl.unsigned_select)
        next_overflow = ctrl.negate_subtract_sel ? (acc_full < prod48) : (sum48 < acc_full);
      else if (ctrl.negate_subtract_sel)
        next_overflow = (acc_full[TOP] != prod48[TOP]) && (sum48[TOP] != acc_full[TOP]);
      else
        next_overflow = (acc_full[TOP] == prod48[TOP]) && (sum48[TOP] != acc_full[TOP]);
    end
    else if (!ctrl.accumulate_enable && ctrl.negate_subtract_sel && ctrl.unsigned_select)
      next_overflow = (prod48 != 48'h0000_0000_0000);
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= macr_ctrl_type'(CONTROL_RESET);
    else
    begin
      if (wr_access && (wr_reg == REG_CONTROL))
      begin
        ctrl.acc_write_inhibit   <= pwdata[6];
        ctrl.square_enable       <= pwdata[4];
        ctrl.operand_count_sel   <= pwdata[3];
        ctrl.negate_subtract_sel <= pwdata[2];
        ctrl.accumulate_enable   <= pwdata[1];
        ctrl.unsigned_select     <= pwdata[0];
      end
      ctrl.clear_data_regs <= 1'b0;
      // Clear beats all; a finishing result beats the next start
      if (clear_now)
        ctrl.overflow_flag <= 1'b0;
      else if (pending)
        ctrl.overflow_flag <= next_overflow;
      else if (op_start)
        ctrl.overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operands and load flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operand_first  <= WORD_RESET;
      operand_second <= WORD_RESET;
      loaded_first   <= 1'b0;
      loaded_second  <= 1'b0;
    end
    else if (clear_now)
    begin
      operand_first  <= WORD_RESET;
      operand_second <= WORD_RESET;
      loaded_first   <= 1'b0;
      loaded_second  <= 1'b0;
    end
    else if (wr_access && (wr_reg == REG_OPERAND_A || wr_reg == REG_OPERAND_B))
    begin
      // Square mode loads both operands from one write
      if (wr_reg == REG_OPERAND_A || ctrl.square_enable)
        operand_first <= pwdata[15:0];
      if (wr_reg == REG_OPERAND_B || ctrl.square_enable)
        operand_second <= pwdata[15:0];
      loaded_first  <= !op_start && (loaded_first || wr_reg == REG_OPERAND_A);
      loaded_second <= !op_start && (loaded_second || wr_reg == REG_OPERAND_B);
    end
  end

  // ----------------------------------------------------------------
  // Accumulator update, one cycle after the operation starts
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending <= 1'b0;
    else
      pending <= op_start;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accumulator_middle_word <= WORD_RESET;
      accumulator_low_word    <= WORD_RESET;
    end
    else if (clear_now)
    begin
      accumulator_middle_word <= WORD_RESET;
      accumulator_low_word    <= WORD_RESET;
    end
    else if (pending && !ctrl.acc_write_inhibit)
    begin
      accumulator_middle_word <= sum48[31:16];
      accumulator_low_word    <= sum48[15:0];
    end
    else if (wr_access && wr_reg == REG_ACC_MIDDLE)
      accumulator_middle_word <= pwdata[15:0];
    else if (wr_access && wr_reg == REG_ACC_LOW)
      accumulator_low_word <= pwdata[15:0];
  end

  // 32-bit builds have no high word storage at all
  generate
    if (ACC_WIDTH > 32)
    begin : g_high
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          accumulator_high_word <= WORD_RESET;
        else if (clear_now)
          accumulator_high_word <= WORD_RESET;
        else if (pending && !ctrl.acc_write_inhibit)
          accumulator_high_word <= sum48[47:32];
        else if (hi_write)
          accumulator_high_word <= pwdata[15:0];
      end
    end
    else
    begin : g_no_high
      assign accumulator_high_word = WORD_RESET;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (rd_reg)
        REG_CONTROL:    prdata <= {24'h00_0000, ctrl};
        REG_OPERAND_A:  prdata <= {16'h0000, operand_first};
        REG_OPERAND_B:  prdata <= {16'h0000, operand_second};
        REG_ACC_HIGH:   prdata <= {16'h0000, accumulator_high_word};
        REG_ACC_MIDDLE: prdata <= {16'h0000, accumulator_middle_word};
        REG_ACC_LOW:    prdata <= {16'h0000, accumulator_low_word};
        REG_RES_UPPER:  prdata <= {16'h0000, result_upper_readback};
        REG_RES_LOWER:  prdata <= {16'h0000, result_lower_readback};
        REG_NONE:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  clear_zeroes_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_now |=> (acc_full == 48'h0 && operand_first == 16'h0 && !ctrl.overflow_flag
                   && !loaded_first && !loaded_second && !ctrl.clear_data_regs))
    else $error("clear did not zero the data registers");

  start_pending_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_start |=> pending ##1 !pending)
    else $error("operation did not complete in one cycle");

  inhibit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_start && ctrl.acc_write_inhibit) |=> ##1 $stable(acc_full))
    else $error("accumulator changed while write inhibited");

  mac_adds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pending && ctrl.accumulate_enable && !ctrl.negate_subtract_sel
     && !ctrl.acc_write_inhibit && !clear_now)
    |=> acc_full == (($past(acc_full) + $past(prod48)) & ACC_MASK))
    else $error("accumulate result wrong");

  plain_product_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl.accumulate_enable && !ctrl.negate_subtract_sel)
    |-> {result_upper_readback, result_lower_readback} ==
        (ctrl.unsigned_select ? prod_u : prod_s))
    else $error("readback is not the product");

  ro_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && (wr_reg == REG_RES_UPPER || wr_reg == REG_RES_LOWER) && !pending)
    |=> ($stable(acc_full) && $stable(operand_first) && $stable(operand_second)
         && $stable(ctrl)))
    else $error("write to readback changed state");

  high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && rd_reg == REG_ACC_HIGH)
    |=> prdata == {16'h0000, $past(acc_full[47:32])})
    else $error("high word read mismatch");

  read_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite) |=> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  sign_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pending && ctrl.accumulate_enable && !ctrl.negate_subtract_sel
     && !ctrl.unsigned_select && !ctrl.acc_write_inhibit && !clear_now
     && !acc_full[TOP] && !prod48[TOP] && sum48[TOP]) |=> ctrl.overflow_flag)
    else $error("signed overflow not flagged");

  low_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && wr_reg == REG_ACC_LOW && !pending)
    |=> accumulator_low_word == $past(pwdata[15:0]))
    else $error("low accumulator write lost");

endmodule : macr_mac_accumulator_readout

// File: tb/macr_apb_master.sv
// APB master model standing in for the processor core
`timescale 1ns/1ps

module macr_apb_master
  import macr_pkg::*;
(
  input  wire logic              pclk,        // Bus clock
  output logic      [ADDR_W-1:0] paddr,       // Byte address
  output logic                   psel,        // Select
  output logic                   penable,     // Access phase
  output logic                   pwrite,      // Write when high
  output logic      [31:0]       pwdata,      // Write data
  input  wire logic [31:0]       prdata,      // Read data
  input  wire logic              pready,      // Slave ready
  input  wire logic              pslverr,     // Slave error
  output logic                   timeout_hit  // Wait bound used up
);
  initial
  begin
    paddr       = 8'h00;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    pwdata      = 32'h0000_0000;
    timeout_hit = 1'b0;
  end

  // ----------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      timeout_hit <= 1'b1;
    rdata   = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never passes for a match
    paddr   <= ~addr;
    pwdata  <= ~wdata;
  endtask : xfer
endmodule : macr_apb_master

// File: tb/macr_mac_accumulator_readout_bench.sv
// Self-checking bench for the MAC accumulator readout block
`timescale 1ns/1ps

module macr_mac_accumulator_readout_bench
  import macr_pkg::*;
  ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pslverr_narrow, timeout_hit;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lfsr_state, r, d;
  logic [7:0]  m_ctrl;
  logic [15:0] m_a, m_b;
  logic [47:0] m_acc;
  logic        m_wa, m_wb;
  int          fails, check_count;
  logic [7:0]  ofs_list [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};

  macr_apb_master macr_apb_master_i (.pclk(pclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timeout_hit(timeout_hit));
  macr_mac_accumulator_readout macr_mac_accumulator_readout_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Narrow build shares the bus; only its error answer is watched
  macr_mac_accumulator_readout #(.ACC_WIDTH(32)) macr_mac_accumulator_readout_narrow_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(pslverr_narrow));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction : rnd

  function automatic logic [47:0] product();
    longint p;
    if (m_ctrl[0])
      p = longint'(m_a) * longint'(m_b);
    else
      p = longint'($signed(m_a)) * longint'($signed(m_b));
    return p[47:0];
  endfunction : product

  function automatic logic [31:0] readback();
    logic [47:0] p;
    logic [47:0] base;
    p = product();
    base = m_ctrl[1] ? m_acc : 48'h0;
    return m_ctrl[2] ? base[31:0] - p[31:0] : base[31:0] + p[31:0];
  endfunction : readback

  function automatic logic [31:0] exp_reg(input logic [7:0] a);
    case (a)
      OFS_CONTROL:    return {25'h0, m_ctrl[6:0]};
      OFS_OPERAND_A:  return {16'h0, m_a};
      OFS_OPERAND_B:  return {16'h0, m_b};
      OFS_ACC_HIGH:   return {16'h0, m_acc[47:32]};
      OFS_ACC_MIDDLE: return {16'h0, m_acc[31:16]};
      OFS_ACC_LOW:    return {16'h0, m_acc[15:0]};
      OFS_RES_UPPER:  return readback() >> 16;
      OFS_RES_LOWER:  return readback() & 32'h0000_FFFF;
      default:        return 32'h0000_0000;
    endcase
  endfunction : exp_reg

  task automatic operate();
    logic [47:0] p;
    p = product();
    if (!m_ctrl[6])
      m_acc = m_ctrl[1] ? (m_ctrl[2] ? m_acc - p : m_acc + p) : (m_ctrl[2] ? -p : p);
    m_wa = 1'b0;
    m_wb = 1'b0;
  endtask : operate

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    logic e;
    macr_apb_master_i.xfer(1'b1, a, v, q, e);
    check({31'h0, e}, {31'h0, a > OFS_RES_LOWER});
    case (a)
      OFS_CONTROL:
      begin
        m_ctrl = {1'b0, v[6], 1'b0, v[4:0]};
        if (v[5])
        begin
          {m_a, m_b, m_acc, m_wa, m_wb} = '0;
        end
      end
      OFS_OPERAND_A, OFS_OPERAND_B:
      begin
        if (a == OFS_OPERAND_A || m_ctrl[4])
          m_a = v[15:0];
        if (a == OFS_OPERAND_B || m_ctrl[4])
          m_b = v[15:0];
        m_wa = m_wa || a == OFS_OPERAND_A;
        m_wb = m_wb || a == OFS_OPERAND_B;
        if (m_ctrl[4] || m_ctrl[3] || (m_wa && m_wb))
          operate();
      end
      OFS_ACC_HIGH:   m_acc[47:32] = v[15:0];
      OFS_ACC_MIDDLE: m_acc[31:16] = v[15:0];
      OFS_ACC_LOW:    m_acc[15:0] = v[15:0];
      default:        ;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    macr_apb_master_i.xfer(1'b0, a, rnd(), q, e);
    check({31'h0, e}, {31'h0, a > OFS_RES_LOWER});
  endtask : rd

  task automatic dump();
    logic [31:0] q;
    foreach (ofs_list[i])
    begin
      rd(ofs_list[i], q);
      if (ofs_list[i] == OFS_CONTROL)
        q = q & 32'h0000_007F;
      check(q, exp_reg(ofs_list[i]));
    end
  endtask : dump

  always @(posedge pclk)
    if (presetn && psel && penable)
      check({31'h0, pslverr_narrow}, {31'h0, paddr == OFS_ACC_HIGH || paddr > OFS_RES_LOWER});

  always @(posedge timeout_hit)
  begin
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    lfsr_state = 32'h0001_5114;
    fails = 0;
    check_count = 0;
    {m_ctrl, m_a, m_b, m_acc, m_wa, m_wb} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    dump();
    wr(8'h20, rnd());
    rd(8'hFC, r);
    check(r, 32'h0000_0000);
    wr(OFS_RES_UPPER, rnd());
    wr(OFS_RES_LOWER, rnd());
    wr(OFS_CONTROL, 32'h0000_0000);
    wr(OFS_OPERAND_A, 32'h0000_0003);
    wr(OFS_OPERAND_B, 32'h0000_0005);
    rd(OFS_ACC_LOW, r);
    check(r, 32'h0000_000F);
    rd(OFS_RES_LOWER, r);
    check(r, 32'h0000_000F);
    dump();
    // Unsigned negate of a nonzero product raises overflow
    wr(OFS_CONTROL, 32'h0000_0005);
    wr(OFS_OPERAND_A, 32'h0000_0002);
    wr(OFS_OPERAND_B, 32'h0000_0003);
    @(posedge pclk);
    rd(OFS_CONTROL, r);
    check(r, 32'h0000_0085);
    wr(OFS_CONTROL, 32'h0000_0020);
    rd(OFS_CONTROL, r);
    check(r, 32'h0000_0000);
    dump();
    repeat (40)
    begin
      r = rnd();
      d = r & 32'hFFFF_FFDF;
      d[5] = (r[31:29] == 3'b000);
      if (d[0] && d[2] && !d[1])
        d[2] = 1'b0;
      wr(OFS_CONTROL, d);
      if (r[28])
        wr(OFS_ACC_HIGH, rnd());
      if (r[27])
        wr(OFS_ACC_MIDDLE, rnd());
      if (r[26])
        wr(OFS_ACC_LOW, rnd());
      if (r[25] || r[24])
        wr(OFS_OPERAND_A, rnd());
      if (r[24] || !r[25])
        wr(OFS_OPERAND_B, rnd());
      if (r[23])
        wr(OFS_OPERAND_B, rnd());
      @(posedge pclk);
      dump();
    end
    tally_and_finish();
  end
endmodule : macr_mac_accumulator_readout_bench
